// ---- design/rap_defs.svh ----
// Purpose: Widths, reset values and idle pin levels for the parallel host port
// Assumes: Included by the package and by the design modules
// Notes:   Definitions only
`ifndef RAP_DEFS_SVH
`define RAP_DEFS_SVH

`define RAP_ADDR_W      4
`define RAP_DATA_W      8
`define RAP_ADDR_RST    4'h0
`define RAP_DATA_RST    8'h00
`define RAP_STROBE_IDLE 1'b1
`define RAP_SYNC_STAGES 2

`endif

// ---- design/rap_pkg.sv ----
// Purpose: Shared types for the parallel host port
// Assumes: rap_defs.svh holds the numeric constants
// Notes:   Write tracker states are one-hot
`include "rap_defs.svh"

package rap_pkg;

	typedef logic [`RAP_ADDR_W-1:0] rap_addr_t;
	typedef logic [`RAP_DATA_W-1:0] rap_data_t;

	typedef enum logic [1:0] {
		RAP_ST_IDLE  = 2'b01,
		RAP_ST_WRITE = 2'b10
	} rap_wr_state_t;

endpackage : rap_pkg

// ---- design/rap_sync_if.sv ----
// Purpose: Carries the synchronised host pins from the sampler to the port logic
// Assumes: All signals are in the core_clk domain
// Notes:   Strobes are active low, as on the pins
`timescale 1ns/1ps

interface rap_sync_if;
	import rap_pkg::*;

	logic      cs_n;
	logic      oe_n;
	logic      we_n;
	rap_addr_t addr;
	rap_data_t dq;

	modport drv (output cs_n, oe_n, we_n, addr, dq);
	modport core (input cs_n, oe_n, we_n, addr, dq);

endinterface : rap_sync_if

// ---- design/rap_pin_sync.sv ----
// Purpose: Two-flop synchronisers for every host pin
// Assumes: Host pins are asynchronous to core_clk
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ps
`include "rap_defs.svh"

module rap_pin_sync
	import rap_pkg::*;
(
	// Clock and reset
	input  wire logic   core_clk,
	input  wire logic   rstn,
	// Raw host pins
	input  wire logic   cs_n_pin,
	input  wire logic   oe_n_pin,
	input  wire logic   we_n_pin,
	input  wire rap_addr_t addr_pin,
	input  wire rap_data_t dq_in,
	// Synchronised side
	rap_sync_if.drv     sif
);

	logic      cs_n_meta;
	logic      oe_n_meta;
	logic      we_n_meta;
	rap_addr_t addr_meta;
	rap_data_t dq_meta;

	// Strobes reset to idle so no access is seen coming out of reset
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			cs_n_meta <= `RAP_STROBE_IDLE;
			oe_n_meta <= `RAP_STROBE_IDLE;
			we_n_meta <= `RAP_STROBE_IDLE;
			sif.cs_n  <= `RAP_STROBE_IDLE;
			sif.oe_n  <= `RAP_STROBE_IDLE;
			sif.we_n  <= `RAP_STROBE_IDLE;
		end else begin
			cs_n_meta <= cs_n_pin;
			oe_n_meta <= oe_n_pin;
			we_n_meta <= we_n_pin;
			sif.cs_n  <= cs_n_meta;
			sif.oe_n  <= oe_n_meta;
			sif.we_n  <= we_n_meta;
		end
	end

	// Address and data are qualified by the strobes downstream
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			addr_meta <= `RAP_ADDR_RST;
			dq_meta   <= `RAP_DATA_RST;
			sif.addr  <= `RAP_ADDR_RST;
			sif.dq    <= `RAP_DATA_RST;
		end else begin
			addr_meta <= addr_pin;
			dq_meta   <= dq_in;
			sif.addr  <= addr_meta;
			sif.dq    <= dq_meta;
		end
	end

endmodule : rap_pin_sync

// ---- design/rap_port.sv ----
// Purpose: Asynchronous SRAM-style host port for the clock and control locations
// Assumes: Register storage sits outside; read data returns combinationally on rd_data
// Notes:   All pins are sampled through two flops, so strobes must last several core_clk cycles
//
// How it works
// - The write strobe pin is the write control for the register locations.
// - The output strobe pin is the read control for the register locations.
// - A write happens only while select and write strobe are both low.
// - A write starts at the later falling edge of select and write strobe.
// - A write ends at the earlier rising edge of select and write strobe.
// - If select falls with or after the write strobe, the data pins stay undriven until select rises.
// - During a write with the output strobe high the data pins are never driven.
// - During a continuous read the pins follow the location picked by the current address.
`timescale 1ns/1ps
`include "rap_defs.svh"

module rap_port
	import rap_pkg::*;
(
	// Clock and reset
	input  wire logic      core_clk,
	input  wire logic      rstn,
	// Host pins
	input  wire logic      cs_n_pin,
	input  wire logic      oe_n_pin,
	input  wire logic      we_n_pin,
	input  wire rap_addr_t addr_pin,
	input  wire rap_data_t dq_in,
	output logic [`RAP_DATA_W-1:0] dq_out,
	output logic           dq_oe,
	// Register side
	output logic [`RAP_ADDR_W-1:0] rd_addr,
	input  wire rap_data_t rd_data,
	output logic           wr_strobe,
	output logic [`RAP_ADDR_W-1:0] wr_addr,
	output logic [`RAP_DATA_W-1:0] wr_data
);

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic rap_overlap(input logic cs_n, input logic we_n);
		rap_overlap = !cs_n && !we_n;
	endfunction : rap_overlap

	function automatic logic rap_read_ok(input logic cs_n, input logic oe_n, input logic we_n);
		rap_read_ok = !cs_n && !oe_n && we_n;
	endfunction : rap_read_ok

	// ------------------------------------------------------------
	// Pin sampling
	// ------------------------------------------------------------
	rap_sync_if sif ();

	rap_pin_sync u_sync (
		.core_clk (core_clk),
		.rstn     (rstn),
		.cs_n_pin (cs_n_pin),
		.oe_n_pin (oe_n_pin),
		.we_n_pin (we_n_pin),
		.addr_pin (addr_pin),
		.dq_in    (dq_in),
		.sif      (sif)
	);

	rap_wr_state_t wr_state_reg;
	rap_wr_state_t wr_state_next;
	logic          cs_n_prev_reg;
	logic          inhibit_reg;
	logic          overlap;
	logic          drive_next;
	rap_addr_t     lat_addr_reg;
	rap_data_t     lat_data_reg;
	logic          wr_strobe_reg;
	rap_addr_t     wr_addr_reg;
	rap_data_t     wr_data_reg;
	rap_addr_t     rd_addr_reg;
	rap_data_t     dq_out_reg;
	logic          dq_oe_reg;

	assign overlap = rap_overlap(sif.cs_n, sif.we_n);

	// ------------------------------------------------------------
	// Write tracking
	// ------------------------------------------------------------
	always_comb begin
		wr_state_next = wr_state_reg;
		case (wr_state_reg)
			RAP_ST_IDLE: begin
				if (overlap) begin
					wr_state_next = RAP_ST_WRITE;
				end
			end
			RAP_ST_WRITE: begin
				if (!overlap) begin
					wr_state_next = RAP_ST_IDLE;
				end
			end
			default: begin
				wr_state_next = RAP_ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			wr_state_reg <= RAP_ST_IDLE;
		end else begin
			wr_state_reg <= wr_state_next;
		end
	end

	// Keep the last values seen inside the overlap; hold time at the end may be zero
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			lat_addr_reg <= `RAP_ADDR_RST;
			lat_data_reg <= `RAP_DATA_RST;
		end else if (overlap) begin
			lat_addr_reg <= sif.addr;
			lat_data_reg <= sif.dq;
		end
	end

	// One-cycle commit after the write closes
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			wr_strobe_reg <= 1'b0;
			wr_addr_reg   <= `RAP_ADDR_RST;
			wr_data_reg   <= `RAP_DATA_RST;
		end else begin
			wr_strobe_reg <= (wr_state_reg == RAP_ST_WRITE) && !overlap;
			if ((wr_state_reg == RAP_ST_WRITE) && !overlap) begin
				wr_addr_reg <= lat_addr_reg;
				wr_data_reg <= lat_data_reg;
			end
		end
	end

	// ------------------------------------------------------------
	// Output inhibit for select-late writes
	// ------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			cs_n_prev_reg <= `RAP_STROBE_IDLE;
			inhibit_reg   <= 1'b0;
		end else begin
			cs_n_prev_reg <= sif.cs_n;
			if (sif.cs_n) begin
				inhibit_reg <= 1'b0;
			end else if (cs_n_prev_reg && !sif.we_n) begin
				inhibit_reg <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// Read path
	// ------------------------------------------------------------
	// Same-sample select and write fall must block at once, not one cycle late
	assign drive_next = rap_read_ok(sif.cs_n, sif.oe_n, sif.we_n) && !inhibit_reg;

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			rd_addr_reg <= `RAP_ADDR_RST;
		end else begin
			rd_addr_reg <= sif.addr;
		end
	end

	// rd_data answers rd_addr in the same cycle
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			dq_out_reg <= `RAP_DATA_RST;
			dq_oe_reg  <= 1'b0;
		end else begin
			dq_oe_reg <= drive_next;
			if (drive_next) begin
				dq_out_reg <= rd_data;
			end
		end
	end

	assign dq_out    = dq_out_reg;
	assign dq_oe     = dq_oe_reg;
	assign rd_addr   = rd_addr_reg;
	assign wr_strobe = wr_strobe_reg;
	assign wr_addr   = wr_addr_reg;
	assign wr_data   = wr_data_reg;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	property p_wr_needs_overlap;
		@(posedge core_clk) disable iff (!rstn)
		wr_strobe_reg |-> $past(overlap, 2) && !$past(overlap);
	endproperty
	a_wr_needs_overlap: assert property (p_wr_needs_overlap)
		else $error("write committed without a select and write overlap");

	property p_wr_start;
		@(posedge core_clk) disable iff (!rstn)
		$rose(overlap) |=> (wr_state_reg == RAP_ST_WRITE);
	endproperty
	a_wr_start: assert property (p_wr_start)
		else $error("write did not start at the later falling strobe");

	property p_wr_end;
		@(posedge core_clk) disable iff (!rstn)
		(wr_state_reg == RAP_ST_WRITE) && !overlap |=> wr_strobe_reg ##1 !wr_strobe_reg;
	endproperty
	a_wr_end: assert property (p_wr_end)
		else $error("write end not a single commit pulse");

	property p_wr_capture;
		@(posedge core_clk) disable iff (!rstn)
		wr_strobe_reg |-> (wr_data_reg == $past(sif.dq, 2)) && (wr_addr_reg == $past(sif.addr, 2));
	endproperty
	a_wr_capture: assert property (p_wr_capture)
		else $error("committed word differs from last write sample");

	property p_late_select_quiet;
		@(posedge core_clk) disable iff (!rstn)
		inhibit_reg && !sif.cs_n |=> !dq_oe_reg;
	endproperty
	a_late_select_quiet: assert property (p_late_select_quiet)
		else $error("data pins driven in a select-late write");

	property p_no_drive_in_write;
		@(posedge core_clk) disable iff (!rstn)
		!sif.we_n |=> !dq_oe_reg;
	endproperty
	a_no_drive_in_write: assert property (p_no_drive_in_write)
		else $error("data pins driven while write strobe low");

	property p_drive_only_read;
		@(posedge core_clk) disable iff (!rstn)
		dq_oe_reg |-> $past(rap_read_ok(sif.cs_n, sif.oe_n, sif.we_n));
	endproperty
	a_drive_only_read: assert property (p_drive_only_read)
		else $error("data pins driven outside a read");

	property p_oe_controls;
		@(posedge core_clk) disable iff (!rstn)
		$rose(dq_oe_reg) |-> !$past(sif.oe_n);
	endproperty
	a_oe_controls: assert property (p_oe_controls)
		else $error("output enabled without output strobe low");

	property p_read_follows;
		@(posedge core_clk) disable iff (!rstn)
		dq_oe_reg |-> dq_out_reg == $past(rd_data);
	endproperty
	a_read_follows: assert property (p_read_follows)
		else $error("read data not from current address");

	property p_we_only_writes;
		@(posedge core_clk) disable iff (!rstn)
		sif.we_n [*3] |-> !wr_strobe_reg;
	endproperty
	a_we_only_writes: assert property (p_we_only_writes)
		else $error("write commit without the write strobe");

endmodule : rap_port

// ---- tb/rap_host_model.sv ----
// Purpose: Host side of the parallel port: drives strobes, address and write data
// Assumes: Pins change 1 ns after a core_clk rising edge
// Notes:   Released data lines show the inverse of the last value
`timescale 1ns/1ps

module rap_host_model
	import rap_pkg::*;
(
	// Clock
	input  wire logic core_clk,
	// Host pins
	output logic      cs_n,
	output logic      oe_n,
	output logic      we_n,
	output rap_addr_t addr,
	output rap_data_t dq_d,
	output logic      dq_en
);
	initial begin
		cs_n  = 1'b1;
		oe_n  = 1'b1;
		we_n  = 1'b1;
		addr  = 4'h0;
		dq_d  = 8'h00;
		dq_en = 1'b0;
	end

	// Write: cs_late puts select after the write strobe
	task automatic wr(input rap_addr_t a, input rap_data_t d, input bit cs_late, input bit oe);
		@(posedge core_clk) #1 addr = a;
		dq_d  = d;
		dq_en = 1'b1;
		@(posedge core_clk) #1 if (cs_late) we_n = 1'b0;
		else cs_n = 1'b0;
		// Four cycles so the synced pins see each step
		repeat (4) @(posedge core_clk);
		#1 if (cs_late) cs_n = 1'b0;
		else we_n = 1'b0;
		oe_n = ~oe;
		repeat (8) @(posedge core_clk);
		#1 we_n = 1'b1;
		// Select stays low and output strobe follows oe: a read window unless oe is clear or select came late
		repeat (4) @(posedge core_clk);
		#1 cs_n = 1'b1;
		oe_n = 1'b1;
		@(posedge core_clk) #1 dq_en = 1'b0;
	endtask : wr

	// Write strobe alone, select stays high
	task automatic we_pulse;
		@(posedge core_clk) #1 we_n = 1'b0;
		repeat (8) @(posedge core_clk);
		#1 we_n = 1'b1;
	endtask : we_pulse

	// Address change during a continuous read
	task automatic move(input rap_addr_t a);
		@(posedge core_clk) #1 addr = a;
	endtask : move

	task automatic rd(input rap_addr_t a);
		@(posedge core_clk) #1 addr = a;
		cs_n = 1'b0;
		oe_n = 1'b0;
		we_n = 1'b1;
	endtask : rd

	task automatic idle;
		@(posedge core_clk) #1 cs_n = 1'b1;
		oe_n = 1'b1;
		we_n = 1'b1;
	endtask : idle
endmodule : rap_host_model

// ---- tb/test_rtc_async_parallel_bus_port.sv ----
// Purpose: Self-checking bench for the parallel host port
// Assumes: Register file modelled here, combinational read
// Notes:   Fixed stimulus only
`timescale 1ns/1ps

module test_rtc_async_parallel_bus_port
	import rap_pkg::*;
;
	logic      core_clk = 1'b0;
	logic      rstn     = 1'b0;
	logic      cs_n, oe_n, we_n, h_en, dq_oe, wr_strobe;
	rap_addr_t addr, rd_addr, wr_addr;
	rap_data_t h_d, dq_in, dq_out, rd_data, wr_data;
	rap_data_t regs [16];
	int        miscompares = 0;
	int        cmp_count   = 0;
	int        oe_cycles   = 0;
	int        wr_cnt      = 0;

	always #2.5 core_clk = ~core_clk;

	// Host overdrives; undriven lines never hold a stale value
	assign dq_in   = h_en ? h_d : (dq_oe ? dq_out : ~h_d);
	assign rd_data = regs[rd_addr];

	always @(posedge core_clk) begin
		if (dq_oe === 1'b1) oe_cycles++;
		if (wr_strobe === 1'b1) begin
			wr_cnt++;
			regs[wr_addr] <= wr_data;
		end
	end

	rap_host_model host_u (.core_clk(core_clk), .cs_n(cs_n), .oe_n(oe_n), .we_n(we_n),
		.addr(addr), .dq_d(h_d), .dq_en(h_en));

	rap_port dut_u (.core_clk(core_clk), .rstn(rstn), .cs_n_pin(cs_n), .oe_n_pin(oe_n),
		.we_n_pin(we_n), .addr_pin(addr), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
		.rd_addr(rd_addr), .rd_data(rd_data), .wr_strobe(wr_strobe), .wr_addr(wr_addr),
		.wr_data(wr_data));

	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t ns: %s", $time, m);
		end
	endtask : chk

	task automatic wrap_up;
		$display("compares %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : wrap_up

	// Write, with or without select-late and output strobe low
	task automatic t_write(input rap_addr_t a, input rap_data_t d, input bit late, input bit oe);
		int o;
		int w;
		o = oe_cycles;
		w = wr_cnt;
		host_u.wr(a, d, late, oe);
		repeat (4) @(posedge core_clk);
		#1 chk(8'(oe_cycles - o), (late || !oe) ? 8'h00 : 8'h04, "data pin drive cycles");
		chk(8'(wr_cnt - w), 8'h01, "write commit count");
		chk(8'(wr_addr), 8'(a), "write address");
		chk(wr_data, d, "write data");
	endtask : t_write

	task automatic t_we_only;
		int w;
		w = wr_cnt;
		host_u.we_pulse();
		repeat (5) @(posedge core_clk);
		#1 chk(8'(wr_cnt - w), 8'h00, "write without select");
	endtask : t_we_only

	task automatic t_read;
		host_u.rd(4'h3);
		repeat (6) @(posedge core_clk);
		#1 chk(8'(dq_oe), 8'h01, "read enable");
		chk(dq_out, 8'hA5, "read data");
		host_u.move(4'h5);
		repeat (6) @(posedge core_clk);
		#1 chk(dq_out, 8'h3C, "read follows address");
		host_u.idle();
		repeat (5) @(posedge core_clk);
		#1 chk(8'(dq_oe), 8'h00, "released after deselect");
	endtask : t_read

	initial begin
		for (int i = 0; i < 16; i++) regs[i] = 8'h00;
		regs[5] = 8'h3C;
		repeat (8) @(posedge core_clk);
		#1 rstn = 1'b1;
		repeat (3) @(posedge core_clk);
		#1 chk(8'(dq_oe), 8'h00, "enable after reset");
		t_write(4'h3, 8'hA5, 1'b0, 1'b0);
		t_read();
		t_we_only();
		t_write(4'h7, 8'h5A, 1'b1, 1'b1);
		t_write(4'h9, 8'hC3, 1'b0, 1'b1);
		wrap_up();
	end

	initial begin
		#20000;
		miscompares++;
		wrap_up();
	end
endmodule : test_rtc_async_parallel_bus_port
